// ### verilog/wtr_regs.svh
/*
 * Register indexes, field positions, reset values and timing counts
 * of the wide counter. Assumes a 32-bit Avalon-MM bus; byte address = 4 * index.
 */
`ifndef WTR_REGS_SVH
`define WTR_REGS_SVH

// ****************************************
// Register indexes
// ****************************************
`define WTR_IDX_INTCTL   8'h0b
`define WTR_IDX_PFLAGS   8'h0c
`define WTR_IDX_CNT_LO   8'h0e
`define WTR_IDX_CNT_HI   8'h0f
`define WTR_IDX_CTRL     8'h10
`define WTR_IDX_PEN      8'h8c
`define WTR_IDX_IRQ_STAT 8'h20
`define WTR_IDX_IRQ_MASK 8'h21

// ****************************************
// Field positions
// ****************************************
`define WTR_CTRL_ON      0
`define WTR_CTRL_SRC     1
`define WTR_CTRL_SYNCB   2
`define WTR_CTRL_AOSC    3
`define WTR_CTRL_PS_LO   4
`define WTR_CTRL_PS_HI   5
`define WTR_CTRL_MASK    8'h3f
`define WTR_WRAP_BIT     0
`define WTR_IRQ_WRAP     0
`define WTR_IRQ_TRIG     1
`define WTR_IRQ_MASK_ALL 8'h03

// ****************************************
// Reset values and counts
// ****************************************
`define WTR_RST_BYTE     8'h00
`define WTR_CNT_ZERO     16'h0000
`define WTR_CNT_MAX      16'hffff
`define WTR_CMP_SPECIAL  4'hb
`define WTR_INSTR_DIV    4

`endif

// ### verilog/wtr_pkg.sv
/*
 * Types shared by the wide counter design files.
 * Assumes wtr_regs.svh supplies the numeric constants.
 */
package wtr_pkg;

  // Prescale ratio encodings of the control register
  typedef enum logic [1:0] {
    WTR_PS_1 = 2'h0,
    WTR_PS_2 = 2'h1,
    WTR_PS_4 = 2'h2,
    WTR_PS_8 = 2'h3
  } wtr_prescale_t;

  // External input arming states
  typedef enum logic [2:0] {
    WTR_EXT_IDLE  = 3'h1,
    WTR_EXT_WAIT  = 3'h2,
    WTR_EXT_ARMED = 3'h4
  } wtr_ext_state_t;

endpackage : wtr_pkg

// ### verilog/wtr_prescaler.sv
/*
 * Prescaler of the wide counter: passes every 1st, 2nd, 4th or 8th tick.
 * Assumes ticks are one-cycle pulses on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module wtr_prescaler
  import wtr_pkg::*;
#(
  parameter int DIV_W = 3
) (
  input  wire logic          i_clk,    // Core clock
  input  wire logic          i_arst_n, // Async reset, low
  input  wire logic          i_clear,  // Clear internal count
  input  wire logic          i_tick,   // Input tick pulse
  input  wire wtr_prescale_t i_sel,    // Division select
  output logic               o_tick    // Divided tick pulse
);

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  logic [DIV_W-1:0] mask;

  if (DIV_W < 3) begin : g_chk
    $error("wtr_prescaler: DIV_W must be at least 3");
  end

  always_comb begin
    mask   = DIV_W'((1 << i_sel) - 1);
    o_tick = i_tick && ((cnt_q & mask) == mask);
    cnt_d  = cnt_q;
    if (i_clear) begin
      cnt_d = '0;
    end else if (i_tick) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : wtr_prescaler

`default_nettype wire

// ### verilog/wtr_top.sv
/*
 * Wide 16-bit timer/counter with prescaler, compare-driven clearing,
 * Avalon-MM register slave and a masked interrupt.
 * Assumes the compare units present mode and value on the core clock and
 * that the external count pins are asynchronous to it.
 */
// What this block does
// - Count wraps FFFFh to 0000h, sets flag
// - Prescale field divides by 1, 2, 4, 8
// - Source bit picks instruction clock or pin
// - External counting waits for first falling edge
// - Special compare mode 1011 clears the count
// - Compare clear never sets the wrap flag
// - Count byte write beats a same-cycle clear
// - Compare value is the last count, period is value + 1 ticks
// - Count bytes survive every reset
// - Control register resets to 00h
// - Count byte writes clear the prescaler
// - Count bytes and control at 0Eh-10h
`timescale 1ns/1ps
`default_nettype none
`include "wtr_regs.svh"

module wtr_top
  import wtr_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic        I_SYS_CLK,          // 40 MHz core clock
  input  wire logic        I_ARST_N,           // Power-on/brown-out reset
  input  wire logic [9:0]  I_AVS_ADDRESS,      // Byte address
  input  wire logic        I_AVS_READ,         // Read request
  input  wire logic        I_AVS_WRITE,        // Write request
  input  wire logic [31:0] I_AVS_WRITEDATA,    // Write data
  input  wire logic [3:0]  I_AVS_BYTEENABLE,   // Byte lanes
  output logic [31:0]      O_AVS_READDATA,     // Read data
  output logic             O_AVS_WAITREQUEST,  // Stall
  input  wire logic        I_EXT_CLK,          // External count pin
  input  wire logic        I_AUX_CLK,          // Aux oscillator output
  input  wire logic [3:0]  I_CMP1_MODE,        // Unit one mode
  input  wire logic [15:0] I_CMP1_VALUE,       // Unit one value pair
  input  wire logic [3:0]  I_CMP2_MODE,        // Unit two mode
  input  wire logic [15:0] I_CMP2_VALUE,       // Unit two value pair
  output logic [15:0]      O_COUNT,            // Current count
  output logic             O_AUX_OSC_EN,       // Aux oscillator enable
  output logic             O_WRAP_REQ,         // Wrap request level
  output logic             O_IRQ               // Interrupt level
);

  if (CNT_W != 16) begin : g_chk
    $error("wtr_top: only a 16-bit count is supported");
  end

  // ****************************************
  // Bus slave
  // ****************************************
  logic       ack_q;
  logic       ack_d;
  logic [7:0] idx;
  logic       wr_go;
  logic       rd_load;
  logic [7:0] wbyte;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // One wait cycle: data is looked up in the first cycle, served in the second
  always_comb begin
    idx     = I_AVS_ADDRESS[9:2];
    wbyte   = I_AVS_BYTEENABLE[0] ? I_AVS_WRITEDATA[7:0] : 8'h00;
    ack_d   = (I_AVS_READ || I_AVS_WRITE) && !ack_q;
    wr_go   = I_AVS_WRITE && ack_q && I_AVS_BYTEENABLE[0];
    rd_load = I_AVS_READ && !ack_q;
  end

  assign O_AVS_WAITREQUEST = (I_AVS_READ || I_AVS_WRITE) && !ack_q;
  assign O_AVS_READDATA    = rdata_q;

  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] intctl_q;
  logic [7:0] intctl_d;
  logic [7:0] pflags_q;
  logic [7:0] pflags_d;
  logic [7:0] pen_q;
  logic [7:0] pen_d;
  logic [7:0] istat_q;
  logic [7:0] istat_d;
  logic [7:0] imask_q;
  logic [7:0] imask_d;
  logic [15:0] count_q;
  logic [15:0] count_d;

  logic wr_lo;
  logic wr_hi;
  logic wrap_ev;
  logic trig;

  wtr_prescale_t ps_sel;
  logic          cnt_on;
  logic          src_ext;

  always_comb begin
    ps_sel  = wtr_prescale_t'(ctrl_q[`WTR_CTRL_PS_HI:`WTR_CTRL_PS_LO]);
    cnt_on  = ctrl_q[`WTR_CTRL_ON];
    src_ext = ctrl_q[`WTR_CTRL_SRC];
    wr_lo   = wr_go && (idx == `WTR_IDX_CNT_LO);
    wr_hi   = wr_go && (idx == `WTR_IDX_CNT_HI);
  end

  // ****************************************
  // Pin synchroniser and edge detect
  // ****************************************
  logic pin_mux;
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_s3_q;
  logic pin_rise;
  logic pin_fall;

  // Mux ahead of the synchroniser so only one async path is sampled
  assign pin_mux  = ctrl_q[`WTR_CTRL_AOSC] ? I_AUX_CLK : I_EXT_CLK;
  assign pin_rise = pin_s2_q && !pin_s3_q;
  assign pin_fall = !pin_s2_q && pin_s3_q;

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= pin_mux;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // ****************************************
  // External arming and instruction clock
  // ****************************************
  localparam int ID_W = $clog2(`WTR_INSTR_DIV);
  localparam logic [ID_W-1:0] ID_LAST = ID_W'(`WTR_INSTR_DIV - 1);

  wtr_ext_state_t ext_q;
  wtr_ext_state_t ext_d;
  logic [ID_W-1:0] idiv_q;
  logic [ID_W-1:0] idiv_d;
  logic            instr_tick;
  logic            raw_tick;
  logic            ps_tick;

  always_comb begin
    idiv_d     = (idiv_q == ID_LAST) ? '0 : idiv_q + 1'b1;
    instr_tick = (idiv_q == ID_LAST);
    ext_d      = ext_q;
    // wait for a falling edge before counting
    case (ext_q)
      WTR_EXT_IDLE: begin
        if (cnt_on && src_ext) begin
          ext_d = WTR_EXT_WAIT;
        end
      end
      WTR_EXT_WAIT: begin
        if (!(cnt_on && src_ext)) begin
          ext_d = WTR_EXT_IDLE;
        end else if (pin_fall) begin
          ext_d = WTR_EXT_ARMED;
        end
      end
      WTR_EXT_ARMED: begin
        if (!(cnt_on && src_ext)) begin
          ext_d = WTR_EXT_IDLE;
        end
      end
      default: begin
        ext_d = WTR_EXT_IDLE;
      end
    endcase
    raw_tick = cnt_on && (src_ext ? ((ext_q == WTR_EXT_ARMED) && pin_rise) : instr_tick);
  end

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ext_q  <= WTR_EXT_IDLE;
      idiv_q <= '0;
    end else begin
      ext_q  <= ext_d;
      idiv_q <= idiv_d;
    end
  end

  wtr_prescaler #(
    .DIV_W (3)
  ) u_prescaler (
    .i_clk    (I_SYS_CLK),
    .i_arst_n (I_ARST_N),
    .i_clear  (wr_lo || wr_hi),
    .i_tick   (raw_tick),
    .i_sel    (ps_sel),
    .o_tick   (ps_tick)
  );

  // ****************************************
  // Count
  // ****************************************
  logic match1;
  logic match2;

  always_comb begin
    match1  = (I_CMP1_MODE == `WTR_CMP_SPECIAL) && (count_q == I_CMP1_VALUE);
    match2  = (I_CMP2_MODE == `WTR_CMP_SPECIAL) && (count_q == I_CMP2_VALUE);
    trig    = (match1 || match2) && ps_tick;
    // a compare clear is no wrap
    wrap_ev = ps_tick && !trig && !wr_lo && !wr_hi && (count_q == `WTR_CNT_MAX);
    count_d = count_q;
    // processor write wins over the clear
    if (wr_lo || wr_hi) begin
      if (wr_lo) begin
        count_d[7:0] = wbyte;
      end
      if (wr_hi) begin
        count_d[15:8] = wbyte;
      end
    end else if (trig) begin
      // zero loaded on the match edge
      count_d = `WTR_CNT_ZERO;
    end else if (ps_tick) begin
      count_d = count_q + 16'h0001;
    end
  end

  // no reset term, the count survives every reset
  always_ff @(posedge I_SYS_CLK) begin
    count_q <= count_d;
  end

  assign O_COUNT = count_q;

  // ****************************************
  // Registers next state
  // ****************************************
  always_comb begin
    ctrl_d   = ctrl_q;
    intctl_d = intctl_q;
    pflags_d = pflags_q;
    pen_d    = pen_q;
    imask_d  = imask_q;
    istat_d  = istat_q;
    if (wr_go) begin
      case (idx)
        `WTR_IDX_CTRL:     ctrl_d   = wbyte & `WTR_CTRL_MASK;
        `WTR_IDX_INTCTL:   intctl_d = wbyte;
        `WTR_IDX_PFLAGS:   pflags_d = wbyte & (pflags_q | ~(8'h01 << `WTR_WRAP_BIT));
        `WTR_IDX_PEN:      pen_d    = wbyte;
        `WTR_IDX_IRQ_MASK: imask_d  = wbyte & `WTR_IRQ_MASK_ALL;
        `WTR_IDX_IRQ_STAT: istat_d  = istat_q & ~wbyte;
        default: begin
        end
      endcase
    end
    // hardware sets the wrap flag, set beats clear
    if (wrap_ev) begin
      pflags_d[`WTR_WRAP_BIT] = 1'b1;
      istat_d[`WTR_IRQ_WRAP]  = 1'b1;
    end
    if (trig) begin
      istat_d[`WTR_IRQ_TRIG] = 1'b1;
    end
  end

  // control loads 00h on power-on reset
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ctrl_q   <= `WTR_RST_BYTE;
      intctl_q <= `WTR_RST_BYTE;
      pflags_q <= `WTR_RST_BYTE;
      pen_q    <= `WTR_RST_BYTE;
      istat_q  <= `WTR_RST_BYTE;
      imask_q  <= `WTR_RST_BYTE;
    end else begin
      ctrl_q   <= ctrl_d;
      intctl_q <= intctl_d;
      pflags_q <= pflags_d;
      pen_q    <= pen_d;
      istat_q  <= istat_d;
      imask_q  <= imask_d;
    end
  end

  // ****************************************
  // Read path and bus handshake
  // ****************************************
  always_comb begin
    rdata_d = rdata_q;
    if (rd_load) begin
      rdata_d = 32'h0000_0000;
      case (idx)
        `WTR_IDX_CNT_LO:   rdata_d[7:0] = count_q[7:0];
        `WTR_IDX_CNT_HI:   rdata_d[7:0] = count_q[15:8];
        `WTR_IDX_CTRL:     rdata_d[7:0] = ctrl_q;
        `WTR_IDX_INTCTL:   rdata_d[7:0] = intctl_q;
        `WTR_IDX_PFLAGS:   rdata_d[7:0] = pflags_q;
        `WTR_IDX_PEN:      rdata_d[7:0] = pen_q;
        `WTR_IDX_IRQ_STAT: rdata_d[7:0] = istat_q;
        `WTR_IDX_IRQ_MASK: rdata_d[7:0] = imask_q;
        default:           rdata_d[7:0] = 8'h00;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign O_AUX_OSC_EN = ctrl_q[`WTR_CTRL_AOSC];
  assign O_WRAP_REQ = pflags_q[`WTR_WRAP_BIT] && pen_q[`WTR_WRAP_BIT];
  assign O_IRQ      = |(istat_q & imask_q);

endmodule : wtr_top

`default_nettype wire

// ### test/wtr_top_props.sv
/* Port checker of wtr_top, bound after the module.
   Assumes one core clock and the asynchronous low reset. */
`timescale 1ns/1ps
`default_nettype none
module wtr_top_props (
  input wire logic        I_SYS_CLK,         // Core clock
  input wire logic        I_ARST_N,          // Reset, low
  input wire logic [9:0]  I_AVS_ADDRESS,     // Byte address
  input wire logic        I_AVS_READ,        // Read
  input wire logic        I_AVS_WRITE,       // Write
  input wire logic [31:0] I_AVS_WRITEDATA,   // Write data
  input wire logic [3:0]  I_AVS_BYTEENABLE,  // Lanes
  input wire logic        O_AVS_WAITREQUEST, // Stall
  input wire logic [3:0]  I_CMP1_MODE,       // Unit one mode
  input wire logic [15:0] I_CMP1_VALUE,      // Unit one value
  input wire logic [15:0] O_COUNT,           // Count
  input wire logic        O_AUX_OSC_EN,      // Aux enable
  input wire logic        O_WRAP_REQ,        // Wrap request
  input wire logic        O_IRQ              // Interrupt
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_ARST_N);
  // A write lands at the edge where waitrequest is low
  logic       wr_go;
  logic [7:0] idx;
  assign wr_go = I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_BYTEENABLE[0];
  assign idx   = I_AVS_ADDRESS[9:2];

  a_wait_one_cycle: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
    else $error("waitrequest too long");
  a_low_byte_wins: assert property (wr_go && idx == 8'h0e |=> O_COUNT[7:0] == $past(I_AVS_WRITEDATA[7:0]))
    else $error("low count byte write lost");
  a_high_byte_wins: assert property (wr_go && idx == 8'h0f |=> O_COUNT[15:8] == $past(I_AVS_WRITEDATA[7:0]))
    else $error("high count byte write lost");
  a_count_steps_one: assert property (!$stable(O_COUNT) |-> O_COUNT == $past(O_COUNT) + 16'h0001 || O_COUNT == 16'h0000 || $past(wr_go))
    else $error("count jumped");
  a_clear_at_match: assert property (I_CMP1_MODE == 4'hb && O_COUNT == I_CMP1_VALUE && !wr_go ##1 !$stable(O_COUNT) |-> O_COUNT == 16'h0000)
    else $error("match did not clear");
  a_wrap_req_cause: assert property ($rose(O_WRAP_REQ) |-> $past(O_COUNT) == 16'hffff || $past(wr_go))
    else $error("wrap request without wrap");
  a_irq_cause: assert property ($rose(O_IRQ) |-> O_COUNT == 16'h0000 || $past(wr_go))
    else $error("interrupt without event");
  a_aux_follows: assert property (wr_go && idx == 8'h10 |=> O_AUX_OSC_EN == $past(I_AVS_WRITEDATA[3]))
    else $error("aux enable not stored");
  a_ctrl_reset_zero: assert property ($rose(I_ARST_N) |-> !O_AUX_OSC_EN && !O_WRAP_REQ && !O_IRQ)
    else $error("outputs not cleared by reset");
endmodule : wtr_top_props
bind wtr_top wtr_top_props props_u (.I_SYS_CLK, .I_ARST_N, .I_AVS_ADDRESS, .I_AVS_READ, .I_AVS_WRITE,
  .I_AVS_WRITEDATA, .I_AVS_BYTEENABLE, .O_AVS_WAITREQUEST, .I_CMP1_MODE, .I_CMP1_VALUE, .O_COUNT,
  .O_AUX_OSC_EN, .O_WRAP_REQ, .O_IRQ);
`default_nettype wire

// ### test/wtr_cmp_model.sv
/* Model of the two compare units: presents mode and value pair.
   Assumes the bench calls set_unit; changes land just after a clock edge. */
`timescale 1ns/1ps
`default_nettype none
module wtr_cmp_model (
  input  wire logic  i_clk,   // Core clock
  output logic [3:0]  o_mode1, // Unit one mode
  output logic [15:0] o_val1,  // Unit one value
  output logic [3:0]  o_mode2, // Unit two mode
  output logic [15:0] o_val2   // Unit two value
);
  initial begin
    o_mode1 = 4'h0;
    o_val1  = 16'h5a5a;
    o_mode2 = 4'h0;
    o_val2  = 16'ha5a5;
  end
  task automatic set_unit(input logic u2, input logic [3:0] m, input logic [15:0] v);
    @(posedge i_clk);
    if (u2) begin
      o_mode2 <= m;
      o_val2  <= v;
    end else begin
      o_mode1 <= m;
      o_val1  <= v;
    end
  endtask : set_unit
endmodule : wtr_cmp_model
`default_nettype wire

// ### test/wtr_top_tb.sv
/* Self-checking bench of wtr_top with the compare unit model.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module wtr_top_tb;
  logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, ext = 1'b0, aux = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [31:0] wdat = 32'h0, rdat, e_d;
  logic [3:0]  be = 4'hf, m1, m2;
  logic [15:0] v1, v2, cnt, v;
  logic        wait_req, aux_en, wrap_req, irq;
  logic [31:0] exp_q[$];
  logic [7:0]  idx_l[6] = '{8'h0b, 8'h0c, 8'h10, 8'h8c, 8'h20, 8'hfc};
  int          mismatches = 0, check_count = 0, n;
  always #12.5 clk = ~clk;
  wtr_top dut_u (.I_SYS_CLK(clk), .I_ARST_N(rst_n), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
    .I_AVS_WRITEDATA(wdat), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wait_req),
    .I_EXT_CLK(ext), .I_AUX_CLK(aux), .I_CMP1_MODE(m1), .I_CMP1_VALUE(v1), .I_CMP2_MODE(m2),
    .I_CMP2_VALUE(v2), .O_COUNT(cnt), .O_AUX_OSC_EN(aux_en), .O_WRAP_REQ(wrap_req), .O_IRQ(irq));
  wtr_cmp_model cmp_u (.i_clk(clk), .o_mode1(m1), .o_val1(v1), .o_mode2(m2), .o_val2(v2));
  // Read data is taken at the edge where waitrequest is low
  always @(posedge clk) if (rd && wait_req === 1'b0) begin
    e_d = exp_q.pop_front();
    `CHK(rdat, e_d)
  end
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge clk);
    rd   <= !w;
    wr   <= w;
    adr  <= {i, 2'b00};
    wdat <= {24'h000000, d};
    do @(posedge clk); while (wait_req !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rchk(input logic [7:0] i, input logic [7:0] d);
    exp_q.push_back({24'h000000, d});
    bus(1'b0, i, 8'h00);
  endtask : rchk
  // Cycles until the count next moves
  task automatic gap();
    logic [15:0] s;
    #1;
    s = cnt;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (cnt === s && n < 200);
  endtask : gap
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h446bad5a));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    foreach (idx_l[k]) rchk(idx_l[k], 8'h00);
    v = 16'($urandom);
    bus(1, 8'h0b, v[7:0]);
    rchk(8'h0b, v[7:0]);
    bus(1, 8'h10, 8'hf8);
    #1 `CHK(aux_en, 1'b1)
    be <= 4'he;
    bus(1, 8'h10, 8'h00);
    be <= 4'hf;
    bus(1, 8'hfc, 8'h5a);
    rchk(8'h10, 8'h38);
    rchk(8'hfc, 8'h00);
    bus(1, 8'h0e, 8'h34);
    bus(1, 8'h0f, 8'h12);
    // Mid-run reset keeps the count
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rchk(8'h10, 8'h00);
    rchk(8'h0e, 8'h34);
    rchk(8'h0f, 8'h12);
    for (int p = 0; p < 4; p++) begin
      bus(1, 8'h10, 8'(p * 16 + 1));
      bus(1, 8'h0e, 8'h00);
      gap();
      `CHK(n > (4 << p) - 4 && n <= (4 << p), 1'b1)
      gap();
      `CHK(n, 4 << p)
    end
    bus(1, 8'h10, 8'h00);
    bus(1, 8'h0f, 8'hff);
    bus(1, 8'h0e, 8'hfd);
    bus(1, 8'h8c, 8'h01);
    bus(1, 8'h21, 8'h03);
    bus(1, 8'h10, 8'h01);
    repeat (3) gap();
    `CHK({wrap_req, irq, cnt}, 18'h30000)
    bus(1, 8'h10, 8'h00);
    rchk(8'h0c, 8'h01);
    rchk(8'h20, 8'h01);
    bus(1, 8'h8c, 8'h00);
    bus(1, 8'h21, 8'h00);
    #1 `CHK({wrap_req, irq}, 2'b00)
    bus(1, 8'h21, 8'h01);
    #1 `CHK(irq, 1'b1)
    bus(1, 8'h20, 8'h01);
    bus(1, 8'h0c, 8'h00);
    rchk(8'h0c, 8'h00);
    `CHK(irq, 1'b0)
    bus(1, 8'h0c, 8'h01);
    rchk(8'h0c, 8'h00);
    bus(1, 8'h21, 8'h03);
    for (int k = 0; k < 3; k++) begin
      v = 16'(3 + $urandom % 8);
      cmp_u.set_unit(k[0], (k == 2) ? 4'ha : 4'hb, v);
      bus(1, 8'h0f, 8'h00);
      bus(1, 8'h0e, 8'h00);
      bus(1, 8'h10, 8'h01);
      repeat ((k == 2) ? 1 : 2) begin
        repeat (v) gap();
        `CHK(cnt, v)
        gap();
        `CHK(cnt, (k == 2) ? v + 16'h0001 : 16'h0000)
        `CHK(n, 4)
      end
      bus(1, 8'h10, 8'h00);
      rchk(8'h0c, 8'h00);
      rchk(8'h20, (k == 2) ? 8'h00 : 8'h02);
      `CHK(irq, k != 2)
      bus(1, 8'h20, 8'h03);
      cmp_u.set_unit(k[0], 4'h0, 16'($urandom));
    end
    cmp_u.set_unit(1'b0, 4'hb, 16'h0006);
    bus(1, 8'h0f, 8'h00);
    bus(1, 8'h0e, 8'h00);
    bus(1, 8'h10, 8'h01);
    repeat (6) gap();
    `CHK(cnt, 16'h0006)
    // Land the write on the edge of the matching tick
    @(posedge clk);
    bus(1, 8'h0e, 8'h55);
    #1 `CHK(cnt, 16'h0055)
    bus(1, 8'h10, 8'h00);
    cmp_u.set_unit(1'b0, 4'h0, 16'($urandom));
    bus(1, 8'h0e, 8'h00);
    for (int s = 0; s < 2; s++) begin
      bus(1, 8'h10, s ? 8'h0b : 8'h03);
      repeat (3) begin
        @(posedge clk);
        ext <= !s[0];
        aux <= s[0];
        repeat (6) @(posedge clk);
        ext <= 1'b0;
        aux <= 1'b0;
        repeat (6) @(posedge clk);
      end
      `CHK(cnt, 16'(2 + 2 * s))
      bus(1, 8'h10, 8'h00);
    end
    finish_test();
  end
endmodule : wtr_top_tb
`default_nettype wire
